/* File: design/usb_suspend_map.vh */
`ifndef USB_SUSPEND_MAP_VH
`define USB_SUSPEND_MAP_VH

// Clock is 100 MHz: 10 ns period
`define CLK_PERIOD_NS      10
`define IDLE_SUSPEND_US    3000
`define IDLE_SUSPEND_CYC   ((`IDLE_SUSPEND_US * 1000) / `CLK_PERIOD_NS + 1)
`define SUSPEND_CLKOFF_US  2000
`define SUSPEND_CLKOFF_CYC ((`SUSPEND_CLKOFF_US * 1000) / `CLK_PERIOD_NS)
`define HOST_RESUME_US     20000
`define HOST_RESUME_CYC    ((`HOST_RESUME_US * 1000) / `CLK_PERIOD_NS)
`define REMOTE_K_US        10000
`define REMOTE_K_CYC       ((`REMOTE_K_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_MAX_US        15000
`define WAKE_MAX_CYC       ((`WAKE_MAX_US * 1000) / `CLK_PERIOD_NS)
`define OSC_STABLE_CYC     1000
`define UNLOCK_CODE        16'hAA37
`define CMD_UNLOCK         8'hB0
`define CNT_W              21

`endif

/* File: design/level_timer.v */
`timescale 1ns/1ps
`default_nettype none
// Counts consecutive cycles of a level and flags once the limit is reached
module level_timer #(
  parameter [20:0] LIMIT = 21'h00000A
) (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        level_i,
  output reg         reached_o
);
  reg [20:0] count;
  always @(posedge sys_clk_i) begin
    if (rst_i || !level_i) begin
      count     <= 21'h000000;
      reached_o <= 1'b0;
    end else if (count != LIMIT) begin
      count     <= count + 21'h000001;
      reached_o <= (count == LIMIT - 21'h000001);
    end
  end
endmodule // level_timer
`default_nettype wire

/* File: design/sticky_flag.v */
`timescale 1ns/1ps
`default_nettype none
// Sticky event flag: a set in the clear cycle wins so no event is lost
module sticky_flag (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        set_i,
  input  wire        clear_i,
  output reg         flag_o
);
  always @(posedge sys_clk_i) begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clear_i)
      flag_o <= 1'b0;
  end
endmodule // sticky_flag
`default_nettype wire

/* File: design/usb_suspend_resume_control.v */
`timescale 1ns/1ps
`default_nettype none
`include "usb_suspend_map.vh"

module usb_suspend_resume_control (
  input  wire        sys_clk_i,
  input  wire        rst_i,
  input  wire        bus_idle_i,
  input  wire        bus_k_state_i,
  input  wire        vbus_present_i,
  input  wire        wake_request_input_i,
  input  wire        chip_select_n_i,
  input  wire        host_write_i,
  input  wire        host_a0_i,
  input  wire [15:0] host_data_i,
  input  wire        go_suspend_bit_i,
  input  wire        clock_running_bit_i,
  input  wire        powered_off_select_i,
  input  wire        chip_select_wake_enable_i,
  input  wire        soft_pullup_enable_i,
  input  wire        external_pullup_select_i,
  input  wire        suspend_irq_enable_i,
  input  wire        resume_irq_enable_i,
  input  wire        clear_suspend_flag_i,
  input  wire        clear_resume_flag_i,
  output reg         suspend_detected_flag_o,
  output reg         resume_detected_flag_o,
  output reg         bus_state_status_o,
  output reg         irq_o,
  output reg         suspend_o,
  output reg         osc_enable_o,
  output reg         clock_gate_o,
  output reg         drive_k_state_o,
  output reg         internal_pullup_o,
  output reg         write_locked_o,
  output reg         normal_operation_o
);
  localparam [2:0] ST_AWAKE   = 3'h0;
  localparam [2:0] ST_SUSPEND = 3'h1;
  localparam [2:0] ST_OSC     = 3'h2;
  localparam [2:0] ST_REMOTE  = 3'h3;
  localparam [2:0] ST_RESUMED = 3'h4;

  // Counts are plain integers; each limit keeps only the counter's 21 bits
  localparam integer IDLE_INT   = `IDLE_SUSPEND_CYC;
  localparam integer HOSTK_INT  = `HOST_RESUME_CYC;
  localparam integer CLKOFF_INT = `SUSPEND_CLKOFF_CYC;
  localparam integer K_INT      = `REMOTE_K_CYC;
  localparam integer OSC_INT    = `OSC_STABLE_CYC;
  localparam [20:0] IDLE_LIM    = IDLE_INT[20:0];
  localparam [20:0] HOSTK_LIM   = HOSTK_INT[20:0];
  localparam [20:0] CLKOFF_LIM  = CLKOFF_INT[20:0];
  localparam [20:0] K_LIM       = K_INT[20:0];
  localparam [20:0] OSC_LIM     = OSC_INT[20:0];

  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [20:0] timer;
  reg        idle_suspended;
  reg        idle_suspended_d;
  reg        go_suspend_d;
  reg        remote_wake;
  reg        unlock_armed;
  reg        clk_off_pending;
  wire       idle_reached;
  wire       host_resume;
  wire       susp_flag;
  wire       resm_flag;
  wire       go_fall;
  wire       app_wake;
  wire       resume_event;
  wire       osc_on_next;

  level_timer #(.LIMIT(IDLE_LIM)) u_idle (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .level_i   (bus_idle_i),
    .reached_o (idle_reached)
  );

  level_timer #(.LIMIT(HOSTK_LIM)) u_hostk (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .level_i   (bus_k_state_i && (state == ST_SUSPEND)),
    .reached_o (host_resume)
  );

  // Bus considered suspended once idle passes the limit, until activity
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      idle_suspended   <= 1'b0;
      idle_suspended_d <= 1'b0;
      go_suspend_d     <= 1'b0;
    end else begin
      // Activity wins, so the live status drops without waiting for the timer
      if (!bus_idle_i)
        idle_suspended <= 1'b0;
      else if (idle_reached)
        idle_suspended <= 1'b1;
      idle_suspended_d <= idle_suspended;
      go_suspend_d     <= go_suspend_bit_i;
    end
  end

  assign go_fall  = go_suspend_d && !go_suspend_bit_i;
  // Chip-select wake only counts while bus power is present
  assign app_wake = wake_request_input_i ||
                    (chip_select_wake_enable_i && !chip_select_n_i && vbus_present_i);
  assign resume_event = (state == ST_OSC) && (timer == OSC_LIM);
  // Clocks stop in suspend when firmware cleared clock-running, or 2 ms on if powered-off
  assign osc_on_next  = !((state == ST_SUSPEND) &&
                          (!clock_running_bit_i ||
                           (powered_off_select_i && !clk_off_pending)));

  sticky_flag u_susp (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (idle_suspended && !idle_suspended_d),
    .clear_i   (clear_suspend_flag_i),
    .flag_o    (susp_flag)
  );

  sticky_flag u_resm (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .set_i     (resume_event),
    .clear_i   (clear_resume_flag_i),
    .flag_o    (resm_flag)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_AWAKE: begin
        if (go_fall)
          next_state = ST_SUSPEND;
      end
      ST_SUSPEND: begin
        if (host_resume || app_wake)
          next_state = ST_OSC;
      end
      ST_OSC: begin
        if (timer == OSC_LIM)
          next_state = remote_wake ? ST_REMOTE : ST_RESUMED;
      end
      ST_REMOTE: begin
        if (timer == K_LIM - 21'h000001)
          next_state = ST_RESUMED;
      end
      ST_RESUMED: next_state = ST_AWAKE;
      default:    next_state = ST_AWAKE;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state           <= ST_AWAKE;
      timer           <= 21'h000000;
      remote_wake     <= 1'b0;
      clk_off_pending <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state)
        timer <= 21'h000000;
      else if (timer != 21'h1FFFFF)
        timer <= timer + 21'h000001;
      if (state == ST_SUSPEND && next_state == ST_OSC)
        remote_wake <= app_wake && !host_resume;
      if (state == ST_AWAKE && go_fall)
        clk_off_pending <= 1'b1;
      else if (state != ST_SUSPEND)
        clk_off_pending <= 1'b0;
      else if (timer == CLKOFF_LIM)
        clk_off_pending <= 1'b0;
    end
  end

  // Unlock is a command then data word; any other write disarms it
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      unlock_armed   <= 1'b0;
      write_locked_o <= 1'b0;
    end else begin
      if (host_write_i && host_a0_i)
        unlock_armed <= (host_data_i[7:0] == `CMD_UNLOCK);
      else if (host_write_i)
        unlock_armed <= 1'b0;
      if (resume_event)
        write_locked_o <= 1'b1;
      else if (host_write_i && !host_a0_i && unlock_armed && host_data_i == `UNLOCK_CODE)
        write_locked_o <= 1'b0;
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      suspend_detected_flag_o <= 1'b0;
      resume_detected_flag_o  <= 1'b0;
      bus_state_status_o      <= 1'b0;
      irq_o                   <= 1'b0;
      suspend_o               <= 1'b0;
      osc_enable_o            <= 1'b1;
      clock_gate_o            <= 1'b1;
      drive_k_state_o         <= 1'b0;
      internal_pullup_o       <= 1'b0;
      normal_operation_o      <= 1'b1;
    end else begin
      suspend_detected_flag_o <= susp_flag;
      resume_detected_flag_o  <= resm_flag;
      bus_state_status_o      <= idle_suspended;
      irq_o <= (susp_flag && suspend_irq_enable_i) ||
               (resm_flag && resume_irq_enable_i);
      // Output suspend only in powered-off mode; cleared as soon as wake starts
      suspend_o <= (next_state == ST_SUSPEND) && powered_off_select_i;
      osc_enable_o <= osc_on_next;
      // Same term as the oscillator, so clocks never stay routed past its stop
      clock_gate_o <= (state == ST_AWAKE) || (state == ST_REMOTE) ||
                      (state == ST_RESUMED) ||
                      ((state == ST_SUSPEND) && osc_on_next);
      drive_k_state_o   <= (next_state == ST_REMOTE);
      internal_pullup_o <= soft_pullup_enable_i && !external_pullup_select_i;
      // Stabilisation plus K-state stays well under the wake bound
      normal_operation_o <= (next_state == ST_AWAKE) || (next_state == ST_RESUMED);
    end
  end
endmodule // usb_suspend_resume_control
`default_nettype wire

/* File: verification/usb_suspend_resume_control_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_suspend_map.vh"
module usb_suspend_resume_control_sva (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic bus_idle_i,
  input wire logic soft_pullup_enable_i,
  input wire logic external_pullup_select_i,
  input wire logic powered_off_select_i,
  input wire logic suspend_irq_enable_i,
  input wire logic resume_irq_enable_i,
  input wire logic suspend_detected_flag_o,
  input wire logic resume_detected_flag_o,
  input wire logic bus_state_status_o,
  input wire logic irq_o,
  input wire logic suspend_o,
  input wire logic osc_enable_o,
  input wire logic clock_gate_o,
  input wire logic drive_k_state_o,
  input wire logic internal_pullup_o,
  input wire logic write_locked_o,
  input wire logic normal_operation_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [20:0] k_cnt;
  logic [20:0] w_cnt;
  // Counters instead of long repetitions, which the tools would unroll
  always @(posedge sys_clk_i) begin
    k_cnt <= drive_k_state_o ? k_cnt + 21'h000001 : 21'h000000;
    w_cnt <= (osc_enable_o && !normal_operation_o) ? w_cnt + 21'h000001 : 21'h000000;
  end
  a_irq_gated: assert property (
    irq_o == (suspend_detected_flag_o && $past(suspend_irq_enable_i)
      || resume_detected_flag_o && $past(resume_irq_enable_i)))
    else $error("irq does not follow flag and enable");
  a_pullup_sel: assert property (
    ($stable(soft_pullup_enable_i) && $stable(external_pullup_select_i)) [*3]
      |-> internal_pullup_o == (soft_pullup_enable_i && !external_pullup_select_i))
    else $error("pull-up output wrong");
  a_suspend_powered_off_select: assert property (suspend_o |-> $past(powered_off_select_i))
    else $error("suspend output outside powered-off mode");
  a_gate_needs_osc: assert property (clock_gate_o |-> osc_enable_o)
    else $error("clock routed with oscillator off");
  a_k_length: assert property ($fell(drive_k_state_o) |-> k_cnt == `REMOTE_K_CYC)
    else $error("remote K length wrong");
  a_wake_bound: assert property (w_cnt <= `WAKE_MAX_CYC)
    else $error("wake-up too long");
  a_status_live: assert property ($fell(bus_idle_i) |-> ##[0:3] !bus_state_status_o)
    else $error("bus state stuck after activity");
  a_lock_on_wake: assert property ($rose(resume_detected_flag_o) |-> ##[0:2] write_locked_o)
    else $error("registers not locked after wake");
  c_suspend: cover property ($rose(suspend_o));
  c_remote_k: cover property ($fell(drive_k_state_o));
  c_unlock: cover property ($fell(write_locked_o));
endmodule // usb_suspend_resume_control_sva
`default_nettype wire

/* File: verification/usb_bus_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module usb_bus_host_model (
  input  wire logic sys_clk_i,
  input  wire logic idle_req_i,
  input  wire logic resume_req_i,
  output var  logic bus_idle_o,
  output var  logic bus_k_state_o
);
  initial {bus_idle_o, bus_k_state_o} = 2'h0;
  // Idle J and host K never overlap on the lines: K wins
  always @(posedge sys_clk_i) begin
    bus_idle_o <= idle_req_i && !resume_req_i;
    bus_k_state_o <= resume_req_i;
  end
endmodule // usb_bus_host_model
`default_nettype wire

/* File: verification/usb_suspend_resume_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usb_suspend_map.vh"
module usb_suspend_resume_control_tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic idle_req, k_req, vbus_present_i, wake_request_input_i, chip_select_n_i;
  logic host_write_i, host_a0_i, go_suspend_bit_i, clock_running_bit_i;
  logic powered_off_select_i, chip_select_wake_enable_i, soft_pullup_enable_i;
  logic external_pullup_select_i, suspend_irq_enable_i, resume_irq_enable_i;
  logic clear_suspend_flag_i, clear_resume_flag_i;
  logic [15:0] host_data_i;
  wire bus_idle_i, bus_k_state_i, suspend_detected_flag_o, resume_detected_flag_o;
  wire bus_state_status_o, irq_o, suspend_o, osc_enable_o, clock_gate_o;
  wire drive_k_state_o, internal_pullup_o, write_locked_o, normal_operation_o;
  wire [10:0] outs = {normal_operation_o, write_locked_o, internal_pullup_o,
    drive_k_state_o, clock_gate_o, osc_enable_o, suspend_o, irq_o,
    bus_state_status_o, resume_detected_flag_o, suspend_detected_flag_o};
  logic [2:0] rows [4] = '{3'h0, 3'h5, 3'h2, 3'h6};
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  usb_bus_host_model i_usb_bus_host_model (.sys_clk_i(sys_clk_i), .idle_req_i(idle_req),
    .resume_req_i(k_req), .bus_idle_o(bus_idle_i), .bus_k_state_o(bus_k_state_i));
  usb_suspend_resume_control i_usb_suspend_resume_control (.*);
  always #5 sys_clk_i = ~sys_clk_i;
  // The design's counts are fixed defines, so the run is long: one full cycle only
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 1700000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_count(input string what, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic wait_out(input int idx, input logic val, input int lim);
    n = 0;
    while (outs[idx] !== val && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic host_wr(input logic a0, input logic [15:0] d);
    host_a0_i = a0;
    host_data_i = d;
    host_write_i = 1'b1;
    step(1);
    host_write_i = 1'b0;
    step(1);
  endtask
  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    {idle_req, k_req, wake_request_input_i, host_write_i, host_a0_i} = 5'h00;
    {go_suspend_bit_i, chip_select_wake_enable_i, soft_pullup_enable_i} = 3'h0;
    {external_pullup_select_i, clear_suspend_flag_i, clear_resume_flag_i} = 3'h0;
    {vbus_present_i, chip_select_n_i, clock_running_bit_i} = 3'h7;
    {powered_off_select_i, suspend_irq_enable_i, resume_irq_enable_i} = 3'h6;
    host_data_i = 16'h0000;
    step(20);
    rst_i = 1'b0;
    step(1);
    check_bit("reset outputs", 1'b1, outs === 11'h460);
    $display("test reset done");
    foreach (rows[i]) begin
      {soft_pullup_enable_i, external_pullup_select_i} = rows[i][2:1];
      step(3);
      check_bit("internal pullup", rows[i][0], internal_pullup_o);
    end
    $display("test pullup done");
    idle_req = 1'b1;
    wait_out(0, 1'b1, `IDLE_SUSPEND_CYC + 20);
    check_count("idle cycles", `IDLE_SUSPEND_CYC, `IDLE_SUSPEND_CYC + 6, n);
    check_bit("bus state", 1'b1, bus_state_status_o);
    step(2);
    check_bit("suspend irq", 1'b1, irq_o);
    clear_suspend_flag_i = 1'b1;
    step(1);
    clear_suspend_flag_i = 1'b0;
    step(3);
    check_bit("flag cleared", 1'b0, suspend_detected_flag_o);
    check_bit("irq cleared", 1'b0, irq_o);
    go_suspend_bit_i = 1'b1;
    step(2);
    check_bit("no entry on rise", 1'b0, suspend_o);
    go_suspend_bit_i = 1'b0;
    wait_out(4, 1'b1, 5);
    check_bit("suspend out", 1'b1, suspend_o);
    wait_out(5, 1'b0, `SUSPEND_CLKOFF_CYC + 10);
    check_count("clock off delay", `SUSPEND_CLKOFF_CYC - 5, `SUSPEND_CLKOFF_CYC + 5, n);
    $display("test suspend done");
    wake_request_input_i = 1'b1;
    wait_out(5, 1'b1, 5);
    check_bit("osc on", 1'b1, osc_enable_o);
    check_bit("gate held", 1'b0, clock_gate_o);
    wait_out(6, 1'b1, `OSC_STABLE_CYC + 10);
    check_count("stabilise", `OSC_STABLE_CYC - 5, `OSC_STABLE_CYC + 5, n);
    idle_req = 1'b0;
    step(3);
    check_bit("suspend out off", 1'b0, suspend_o);
    check_bit("resume irq masked", 1'b0, irq_o);
    check_bit("write lock", 1'b1, write_locked_o);
    check_bit("status live", 1'b0, bus_state_status_o);
    check_bit("remote K", 1'b1, drive_k_state_o);
    resume_irq_enable_i = 1'b1;
    step(3);
    check_bit("resume irq", 1'b1, irq_o);
    wait_out(10, 1'b1, `WAKE_MAX_CYC);
    check_bit("normal again", 1'b1, normal_operation_o);
    check_bit("K released", 1'b0, drive_k_state_o);
    wake_request_input_i = 1'b0;
    host_wr(1'b0, `UNLOCK_CODE);
    check_bit("data alone", 1'b1, write_locked_o);
    host_wr(1'b1, {8'h00, `CMD_UNLOCK});
    host_wr(1'b0, `UNLOCK_CODE);
    step(2);
    check_bit("unlocked", 1'b0, write_locked_o);
    $display("test wake done");
    clock_running_bit_i = 1'b0;
    go_suspend_bit_i = 1'b1;
    step(2);
    go_suspend_bit_i = 1'b0;
    step(3);
    check_bit("clock off at once", 1'b0, osc_enable_o);
    check_bit("gate off", 1'b0, clock_gate_o);
    {chip_select_wake_enable_i, chip_select_n_i, vbus_present_i} = 3'h4;
    step(5);
    check_bit("cs wake needs vbus", 1'b0, osc_enable_o);
    vbus_present_i = 1'b1;
    wait_out(5, 1'b1, 5);
    check_bit("cs wake", 1'b1, osc_enable_o);
    $display("test cs wake done");
    wrap_up;
  end
endmodule // usb_suspend_resume_control_tb
bind usb_suspend_resume_control usb_suspend_resume_control_sva i_usb_suspend_resume_control_sva (.*);
`default_nettype wire
